// ===== bench/status_pin_board.sv
// Board-side model of the status pin net and its resistors
`timescale 1ns/10ps
module status_pin_board #(
    parameter bit EXT_PULLUP = 1'b0
) (
    input  wire logic clk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic pullup_en,
    input  wire logic pulldown_en,
    output logic      pin_level
);
    logic float_r = 1'b0;

    // A net nobody holds shows a changing level, never a kind constant
    always @(posedge clk) begin
        float_r <= ~float_r;
    end

    always_comb begin
        if (pin_oe)
            pin_level = pin_out;
        else if (EXT_PULLUP || pullup_en)
            pin_level = 1'b1;
        else if (pulldown_en)
            pin_level = 1'b0;
        else
            pin_level = float_r;
    end
endmodule

// ===== bench/status_pin_ctrl_bench.sv
// Self-checking bench for the status pin and pad configuration block
`timescale 1ns/10ps
module status_pin_ctrl_bench;
    import status_pin_pkg::*;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    reg_addr_t   reg_addr = 8'h00;
    reg_data_t   reg_wdata = 16'h0000;
    reg_data_t   reg_rdata;
    logic        reg_rd_valid;
    logic [10:0] src_in = 11'h000;
    logic        int_en = 1'b1;
    logic        three_wire_mode = 1'b0;
    logic        status_pin_out, status_pin_oe, pin_level, clk_out_enable;
    logic        status_pin_pullup_en, status_pin_pulldown_en;
    logic        data_pin_pullup_en, serial_clock_pin_pullup_en;
    logic        data_pin_strength_apply;
    logic [1:0]  status_pin_strength, data_pin_strength;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;

    status_pin_ctrl i_status_pin_ctrl (
        .ref_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rd_valid,
        .apll_lock(src_in[0]), .dpll_lock(src_in[1]),
        .ref0_loss_monitor(src_in[2]), .ref1_loss_monitor(src_in[3]),
        .crystal_loss_monitor(src_in[4]),
        .ref0_activity_monitor(src_in[5]), .ref1_activity_monitor(src_in[6]),
        .ref0_invalid(src_in[7]), .ref1_invalid(src_in[8]),
        .chip_int_status(src_in[9]), .chip_int_enable(int_en),
        .startup_done(src_in[10]), .three_wire_mode,
        .status_pin_out, .status_pin_oe, .status_pin_pullup_en,
        .status_pin_pulldown_en, .status_pin_strength, .data_pin_pullup_en,
        .serial_clock_pin_pullup_en, .data_pin_strength,
        .data_pin_strength_apply, .clk_out_enable
    );

    status_pin_board i_status_pin_board (
        .clk(ref_clk), .pin_out(status_pin_out), .pin_oe(status_pin_oe),
        .pullup_en(status_pin_pullup_en),
        .pulldown_en(status_pin_pulldown_en), .pin_level(pin_level)
    );

    always #12.5 ref_clk = ~ref_clk;

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ck1(input logic got, input logic exp);
        check({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic do_reset;
        @(posedge ref_clk);
        arst_n <= 1'b0;
        src_in <= 11'h000;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // Write is taken at the strobe edge; pads follow one edge later
    task automatic wr(input reg_addr_t a, input reg_data_t d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input reg_addr_t a, output reg_data_t d);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1;
        ck1(reg_rd_valid, 1'b1);
        d = reg_rdata;
    endtask

    task automatic drive(input logic [10:0] v);
        @(posedge ref_clk);
        src_in <= v;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_reset;
        reg_data_t d;
        ck1(clk_out_enable, 1'b0);
        check({12'h000, status_pin_strength, data_pin_strength},
              16'h000A);
        check({12'h000, status_pin_pullup_en, status_pin_pulldown_en,
               data_pin_pullup_en, serial_clock_pin_pullup_en},
              16'h000B);
        rd(8'h00, d);
        check(d, 16'h002F);
        rd(8'h01, d);
        check(d, 16'h0200);
        rd(8'h03, d);
        check(d, 16'h0000);
    endtask

    task automatic t_gate;
        drive(11'h002);
        ck1(clk_out_enable, 1'b0);
        drive(11'h001);
        ck1(clk_out_enable, 1'b1);
        drive(11'h000);
        ck1(clk_out_enable, 1'b1);
        do_reset();
        wr(8'h00, 16'h006F);
        drive(11'h001);
        ck1(clk_out_enable, 1'b0);
        drive(11'h002);
        ck1(clk_out_enable, 1'b1);
        do_reset();
        wr(8'h00, 16'h00AF);
        ck1(clk_out_enable, 1'b1);
    endtask

    task automatic t_pads;
        reg_data_t d;
        @(posedge ref_clk);
        three_wire_mode <= 1'b1;
        wr(8'h00, 16'h0011);
        check({12'h000, status_pin_strength, data_pin_strength},
              16'h0005);
        check({13'h0000, data_pin_strength_apply, data_pin_pullup_en,
               serial_clock_pin_pullup_en}, 16'h0005);
        wr(8'h01, 16'h1200);
        check({14'h0000, status_pin_strength}, 16'h0000);
        wr(8'h00, 16'h002E);
        check({12'h000, status_pin_strength, data_pin_pullup_en,
               serial_clock_pin_pullup_en}, 16'h000E);
        // Pull-down only with open-drain off, as software must
        wr(8'h01, 16'h0400);
        check({14'h0000, status_pin_pullup_en, status_pin_pulldown_en},
              16'h0001);
        // Reserved bits drop; open-drain stays off beside the pull-down
        wr(8'h01, 16'hEFFF);
        rd(8'h01, d);
        check(d, 16'h0F1F);
        @(posedge ref_clk);
        three_wire_mode <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        ck1(data_pin_strength_apply, 1'b0);
    endtask

    task automatic t_sources;
        int        k;
        int        p;
        reg_data_t d;
        for (p = 0; p < 2; p++) begin
            for (k = 0; k < 11; k++) begin
                wr(8'h01, 16'h0200 | 16'(p << 8) | 16'(k));
                drive(11'h001 << k);
                ck1(status_pin_out,
                    ~p[0]);
                ck1(status_pin_oe, 1'b1);
                rd(8'h02, d);
                check(d, (k < 5) ? {14'h0000, ~p[0], 1'b0}
                                 : 16'h0000);
                drive(~(11'h001 << k));
                ck1(status_pin_out,
                    p[0]);
            end
            // Only listed source codes are ever written
            wr(8'h01, 16'h021E | 16'(p << 8));
            drive(11'h7FF);
            ck1(status_pin_out, 1'b0);
            wr(8'h01, 16'h021F | 16'(p << 8));
            drive(11'h000);
            ck1(status_pin_out, 1'b0);
        end
        wr(8'h01, 16'h0209);
        drive(11'h200);
        ck1(status_pin_out, 1'b1);
        @(posedge ref_clk);
        int_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        ck1(status_pin_out, 1'b0);
        @(posedge ref_clk);
        int_en <= 1'b1;
    endtask

    task automatic t_od_hiz;
        wr(8'h01, 16'h1200);
        drive(11'h001);
        ck1(status_pin_oe, 1'b0);
        ck1(pin_level, 1'b1);
        drive(11'h000);
        ck1(status_pin_oe, 1'b1);
        ck1(pin_level, 1'b0);
        wr(8'h01, 16'h1300);
        ck1(status_pin_oe, 1'b0);
        drive(11'h001);
        ck1(pin_level, 1'b0);
        wr(8'h01, 16'h1A00);
        ck1(status_pin_oe, 1'b0);
        ck1(status_pin_pullup_en, 1'b1);
        wr(8'h01, 16'h0C00);
        ck1(status_pin_oe, 1'b0);
        ck1(pin_level, 1'b0);
    endtask

    initial begin
        do_reset();
        t_reset();
        t_gate();
        t_pads();
        t_sources();
        t_od_hiz();
        stop_test();
    end
endmodule

// ===== src/startup_gate.sv
// Startup gating of the clock output drivers on PLL lock
`timescale 1ns/10ps
module startup_gate (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire status_pin_pkg::gate_mode_t mode,
    input  wire logic                      apll_lock,
    input  wire logic                      dpll_lock,
    output logic                           clk_out_enable
);
    import status_pin_pkg::*;

    typedef struct packed {
        logic released;
    } gate_state_t;

    gate_state_t g_r;
    gate_state_t g_nxt;

    always_comb begin
        g_nxt = g_r;
        case (mode)
            GATE_APLL: if (apll_lock) g_nxt.released = 1'b1;
            GATE_DPLL: if (dpll_lock) g_nxt.released = 1'b1;
            GATE_OFF: g_nxt.released = 1'b1;
            // Reserved code: treated as no gating rather than a hang
            default: g_nxt.released = 1'b1;
        endcase
        // Never cleared once set: a later lock loss must not regate
        if (g_r.released) g_nxt.released = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            g_r <= '0;
        end else begin
            g_r <= g_nxt;
        end
    end

    assign clk_out_enable = g_r.released;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_gate_sticky: assert property (
        clk_out_enable |=> clk_out_enable)
        else $error("clock outputs regated after release");
    chk_gate_apll_lock: assert property (
        !clk_out_enable && mode == GATE_APLL && apll_lock
        |=> clk_out_enable)
        else $error("analog lock did not release outputs");
    chk_gate_hold_dpll: assert property (
        !clk_out_enable && mode == GATE_DPLL && !dpll_lock
        |=> !clk_out_enable)
        else $error("outputs released without digital lock");
    chk_gate_none: assert property (
        mode == GATE_OFF |=> clk_out_enable)
        else $error("outputs gated in no-gating mode");
endmodule

// ===== src/status_pin_ctrl.sv
// Status pin routing, pad configuration registers and startup gating
`timescale 1ns/10ps
`include "status_pin_map.svh"
module status_pin_ctrl (
    input  wire logic                     ref_clk,
    input  wire logic                     arst_n,
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire status_pin_pkg::reg_addr_t reg_addr,
    input  wire status_pin_pkg::reg_data_t reg_wdata,
    output status_pin_pkg::reg_data_t     reg_rdata,
    output logic                          reg_rd_valid,
    input  wire logic                     apll_lock,
    input  wire logic                     dpll_lock,
    input  wire logic                     ref0_loss_monitor,
    input  wire logic                     ref1_loss_monitor,
    input  wire logic                     crystal_loss_monitor,
    input  wire logic                     ref0_activity_monitor,
    input  wire logic                     ref1_activity_monitor,
    input  wire logic                     ref0_invalid,
    input  wire logic                     ref1_invalid,
    input  wire logic                     chip_int_status,
    input  wire logic                     chip_int_enable,
    input  wire logic                     startup_done,
    input  wire logic                     three_wire_mode,
    output logic                          status_pin_out,
    output logic                          status_pin_oe,
    output logic                          status_pin_pullup_en,
    output logic                          status_pin_pulldown_en,
    output logic [1:0]                    status_pin_strength,
    output logic                          data_pin_pullup_en,
    output logic                          serial_clock_pin_pullup_en,
    output logic [1:0]                    data_pin_strength,
    output logic                          data_pin_strength_apply,
    output logic                          clk_out_enable
);
    import status_pin_pkg::*;

    typedef struct packed {
        logic [7:0]  pad_cfg;
        logic [15:0] pin_cfg;
        logic [15:0] rdata;
        logic        rd_valid;
        logic        pin_out;
        logic        pin_oe;
        logic        pin_pu;
        logic        pin_pd;
        logic [1:0]  pin_str;
        logic        data_pu;
        logic        clk_pu;
        logic [1:0]  data_str;
        logic        data_apply;
        logic        readback;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    logic [1:0]  rst_sync_r;
    logic        rst_n;
    source_t     src;
    logic        raw;
    logic        level;
    logic        od;
    logic        hiz;
    logic        pol;

    // Reset enters at once but lifts only in step with ref_clk
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    assign src = source_t'(s_r.pin_cfg[`SRC_HI:`SRC_LO]);
    assign od  = s_r.pin_cfg[`OD_BIT];
    assign hiz = s_r.pin_cfg[`HIZ_BIT];
    assign pol = s_r.pin_cfg[`POL_BIT];

    always_comb begin
        raw = 1'b0;
        case (src)
            S_APLL:      raw = apll_lock;
            S_DPLL:      raw = dpll_lock;
            S_REF0_LOSS: raw = ref0_loss_monitor;
            S_REF1_LOSS: raw = ref1_loss_monitor;
            S_XTAL_LOSS: raw = crystal_loss_monitor;
            S_REF0_ACT:  raw = ref0_activity_monitor;
            S_REF1_ACT:  raw = ref1_activity_monitor;
            S_REF0_INV:  raw = ref0_invalid;
            S_REF1_INV:  raw = ref1_invalid;
            S_INTERRUPT: raw = chip_int_status & chip_int_enable;
            S_READY:     raw = startup_done;
            S_LOW:       raw = 1'b0;
            // Reserved codes fall to a low raw value; polarity still applies to it
            default:     raw = 1'b0;
        endcase
        // A forced low must stay low, so polarity does not touch it
        if (src == S_NO_POL || src == S_LOW) begin
            level = raw;
        end else begin
            level = raw ^ pol;
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_valid = 1'b0;
        if (reg_wr_en) begin
            case (reg_addr)
                `PAD_CFG_OFFSET:
                    s_nxt.pad_cfg = reg_wdata[7:0] & `PAD_CFG_MASK;
                `PIN_CFG_OFFSET:
                    s_nxt.pin_cfg = reg_wdata & `PIN_CFG_MASK;
                default: ;
            endcase
        end
        if (reg_rd_en) begin
            s_nxt.rd_valid = 1'b1;
            case (reg_addr)
                `PAD_CFG_OFFSET:  s_nxt.rdata = {8'h00, s_r.pad_cfg};
                `PIN_CFG_OFFSET:  s_nxt.rdata = s_r.pin_cfg;
                `READBACK_OFFSET: begin
                    s_nxt.rdata = 16'h0000;
                    s_nxt.rdata[`READBACK_BIT] = s_r.readback;
                end
                default:          s_nxt.rdata = 16'h0000;
            endcase
        end

        // Tristate wins over both drive styles
        if (hiz) begin
            s_nxt.pin_out = 1'b0;
            s_nxt.pin_oe  = 1'b0;
        end else if (od) begin
            // Only ever pulls low; a released pin floats to the pull-up
            s_nxt.pin_out = 1'b0;
            s_nxt.pin_oe  = ~level;
        end else begin
            s_nxt.pin_out = level;
            s_nxt.pin_oe  = 1'b1;
        end
        s_nxt.readback = (src <= S_XTAL_LOSS) ? level : 1'b0;

        s_nxt.pin_pu = s_r.pin_cfg[`PU_BIT];
        s_nxt.pin_pd = s_r.pin_cfg[`PD_BIT];
        s_nxt.pin_str = od ? s_r.pad_cfg[`OD_STR_HI:`OD_STR_LO]
                           : s_r.pad_cfg[`PP_STR_HI:`PP_STR_LO];
        s_nxt.data_pu = s_r.pad_cfg[`DATA_PU_BIT];
        s_nxt.clk_pu  = s_r.pad_cfg[`SCLK_PU_BIT];
        s_nxt.data_str = s_r.pad_cfg[`PP_STR_HI:`PP_STR_LO];
        s_nxt.data_apply = three_wire_mode;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r          <= '0;
            s_r.pad_cfg  <= `PAD_CFG_RESET;
            s_r.pin_cfg  <= `PIN_CFG_RESET;
            s_r.pin_pu   <= 1'b1;
            s_r.pin_str  <= 2'h2;
            s_r.data_pu  <= 1'b1;
            s_r.clk_pu   <= 1'b1;
            s_r.data_str <= 2'h2;
        end else begin
            s_r <= s_nxt;
        end
    end

    startup_gate u_gate (
        .clk            (ref_clk),
        .rst_n          (rst_n),
        .mode           (gate_mode_t'(s_r.pad_cfg[`GATE_HI:`GATE_LO])),
        .apll_lock      (apll_lock),
        .dpll_lock      (dpll_lock),
        .clk_out_enable (clk_out_enable)
    );

    assign reg_rdata                  = s_r.rdata;
    assign reg_rd_valid               = s_r.rd_valid;
    assign status_pin_out             = s_r.pin_out;
    assign status_pin_oe              = s_r.pin_oe;
    assign status_pin_pullup_en       = s_r.pin_pu;
    assign status_pin_pulldown_en     = s_r.pin_pd;
    assign status_pin_strength        = s_r.pin_str;
    assign data_pin_pullup_en         = s_r.data_pu;
    assign serial_clock_pin_pullup_en = s_r.clk_pu;
    assign data_pin_strength          = s_r.data_str;
    assign data_pin_strength_apply    = s_r.data_apply;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence od_normal_s;
        od && !hiz && !pol && src == S_APLL;
    endsequence
    sequence pad_write_no_data_pu_s;
        reg_wr_en && reg_addr == `PAD_CFG_OFFSET
            && !reg_wdata[`DATA_PU_BIT] ##1 !reg_wr_en;
    endsequence

    chk_od_pull_low: assert property (
        od_normal_s ##0 !apll_lock |=> status_pin_oe && !status_pin_out)
        else $error("open-drain pin not pulled low for 0");
    chk_od_release: assert property (
        od_normal_s ##0 apll_lock |=> !status_pin_oe)
        else $error("open-drain pin not released for 1");
    chk_od_inverted: assert property (
        od && !hiz && pol && src == S_DPLL && dpll_lock
        |=> status_pin_oe && !status_pin_out)
        else $error("inverted open-drain not pulled low for 1");
    chk_hiz_wins: assert property (
        hiz |=> !status_pin_oe)
        else $error("tristate pin still driven");
    chk_pp_polarity: assert property (
        !od && !hiz && pol && src == S_DPLL
        |=> status_pin_oe && status_pin_out == !$past(dpll_lock))
        else $error("inverted push-pull level wrong");
    chk_src_loss: assert property (
        !od && !hiz && !pol && src == S_REF1_LOSS
        |=> status_pin_out == $past(ref1_loss_monitor))
        else $error("ref1 loss not routed");
    chk_forced_low: assert property (
        !od && !hiz && src == S_LOW |=> status_pin_oe && !status_pin_out)
        else $error("forced low source not low");
    chk_no_polarity: assert property (
        !od && !hiz && pol && src == S_NO_POL |=> !status_pin_out)
        else $error("polarity applied to source 0x1F");
    chk_readback_zero: assert property (
        src > S_XTAL_LOSS
        ##1 reg_rd_en && reg_addr == `READBACK_OFFSET
        |=> reg_rd_valid && reg_rdata == 16'h0000)
        else $error("readback not zero for high source");
    chk_data_pullup: assert property (
        pad_write_no_data_pu_s |=> !data_pin_pullup_en)
        else $error("data pin pull-up not cleared by write");
    chk_pulldown_follows: assert property (
        s_r.pin_cfg[`PD_BIT] |=> status_pin_pulldown_en)
        else $error("pull-down enable not applied");
    chk_od_strength: assert property (
        od |=> status_pin_strength == $past(s_r.pad_cfg[3:2]))
        else $error("open-drain strength not applied");

    sequence readback_low_src_s;
        !od && !hiz && src <= S_XTAL_LOSS
            ##1 reg_rd_en && reg_addr == `READBACK_OFFSET;
    endsequence

    chk_readback_level: assert property (
        readback_low_src_s |=> reg_rdata[`READBACK_BIT]
            == $past(status_pin_out))
        else $error("readback does not follow driven level");
    chk_src_apll: assert property (
        !od && !hiz && !pol && src == S_APLL
        |=> status_pin_out == $past(apll_lock))
        else $error("analog lock not routed");
    chk_src_activity: assert property (
        !od && !hiz && !pol && src == S_REF0_ACT
        |=> status_pin_out == $past(ref0_activity_monitor))
        else $error("ref0 activity not routed");
    chk_src_invalid: assert property (
        !od && !hiz && !pol && src == S_REF1_INV
        |=> status_pin_out == $past(ref1_invalid))
        else $error("ref1 invalid not routed");
    chk_src_interrupt: assert property (
        !od && !hiz && !pol && src == S_INTERRUPT
        |=> status_pin_out == $past(chip_int_status && chip_int_enable))
        else $error("qualified interrupt not routed");
    chk_src_ready: assert property (
        !od && !hiz && !pol && src == S_READY
        |=> status_pin_out == $past(startup_done))
        else $error("device ready not routed");
    chk_pullup_on: assert property (
        s_r.pin_cfg[`PU_BIT] |=> status_pin_pullup_en)
        else $error("status pin pull-up not applied");
    chk_pullup_off: assert property (
        !s_r.pin_cfg[`PU_BIT] |=> !status_pin_pullup_en)
        else $error("status pin pull-up not removed");
    chk_pulldown_off: assert property (
        !s_r.pin_cfg[`PD_BIT] |=> !status_pin_pulldown_en)
        else $error("pull-down enable not removed");
    chk_data_pullup_on: assert property (
        s_r.pad_cfg[`DATA_PU_BIT] |=> data_pin_pullup_en)
        else $error("data pin pull-up not applied");
    chk_clock_pullup_on: assert property (
        s_r.pad_cfg[`SCLK_PU_BIT] |=> serial_clock_pin_pullup_en)
        else $error("clock pin pull-up not applied");
    chk_clock_pullup_off: assert property (
        !s_r.pad_cfg[`SCLK_PU_BIT] |=> !serial_clock_pin_pullup_en)
        else $error("clock pin pull-up not removed");
    chk_pp_strength: assert property (
        !od |=> status_pin_strength
            == $past(s_r.pad_cfg[`PP_STR_HI:`PP_STR_LO]))
        else $error("push-pull strength not applied");
    chk_data_strength: assert property (
        three_wire_mode |=> data_pin_strength_apply
            && data_pin_strength
            == $past(s_r.pad_cfg[`PP_STR_HI:`PP_STR_LO]))
        else $error("data pin strength not applied");
    chk_apply_off: assert property (
        !three_wire_mode |=> !data_pin_strength_apply)
        else $error("data pin strength applied outside three-wire");
    chk_hiz_pulls: assert property (
        hiz && s_r.pin_cfg[`PU_BIT] |=> status_pin_pullup_en)
        else $error("tristate dropped the pull-up");
    chk_pp_driven: assert property (
        !od && !hiz |=> status_pin_oe)
        else $error("push-pull pin not driven");
endmodule

// ===== src/status_pin_map.svh
// Offsets, field positions, reset values and codes of the status pin block
// What this block does
// - Startup gating 0 holds clock outputs off until analog lock, 1 until digital
// - Startup gating 2 never gates clock outputs; code 3 is reserved
// - Open-drain strength applies to status pin in open-drain mode
// - Data pin pull-up bit set enables the data pin pull-up
// - Clock pin pull-up bit set enables the serial clock pin pull-up
// - Open-drain, normal polarity: value 0 pulls low, value 1 releases
// - Open-drain, inverted polarity: value 1 pulls low, value 0 releases
// - Tristate bit set puts the status pin in high impedance
// - Pull-down bit enables pull-down; software avoids it in open-drain mode
// - Status pin weak pull-up bit enables pull-up, set after reset
// - Polarity bit selects true value or inverse on the status pin
// - Polarity is ignored for source code 0x1F
// - Source 0 routes analog lock, source 1 routes digital lock
// - Sources 2, 3, 4 route loss flags of ref0, ref1, crystal
// - Sources 5 and 6 route activity status of ref0 and ref1
// - Sources 7 and 8 route reference-invalid of ref0 and ref1
// - Source 9 routes interrupt status qualified by interrupt enable
// - Source 0xA routes device ready after startup completes
// - Source 0x1E forces the pin low; software avoids unlisted codes
// - Readback bit shows driven pin value for sources 0..4, else 0
`ifndef STATUS_PIN_MAP_SVH
`define STATUS_PIN_MAP_SVH

`define PAD_CFG_OFFSET      8'h00
`define PIN_CFG_OFFSET      8'h01
`define READBACK_OFFSET     8'h02

`define PAD_CFG_RESET       8'h2F
`define PIN_CFG_RESET       16'h0200
`define PAD_CFG_MASK        8'hFF
`define PIN_CFG_MASK        16'h1F1F

`define GATE_HI             7
`define GATE_LO             6
`define PP_STR_HI           5
`define PP_STR_LO           4
`define OD_STR_HI           3
`define OD_STR_LO           2
`define DATA_PU_BIT         1
`define SCLK_PU_BIT         0

`define OD_BIT              12
`define HIZ_BIT             11
`define PD_BIT              10
`define PU_BIT              9
`define POL_BIT             8
`define SRC_HI              4
`define SRC_LO              0
`define READBACK_BIT        1

`define GATE_ON_APLL        2'h0
`define GATE_ON_DPLL        2'h1
`define GATE_NONE           2'h2
`define GATE_RESERVED       2'h3

`define SRC_APLL            5'h00
`define SRC_DPLL            5'h01
`define SRC_REF0_LOSS       5'h02
`define SRC_REF1_LOSS       5'h03
`define SRC_XTAL_LOSS       5'h04
`define SRC_REF0_ACT        5'h05
`define SRC_REF1_ACT        5'h06
`define SRC_REF0_INVALID    5'h07
`define SRC_REF1_INVALID    5'h08
`define SRC_INTERRUPT       5'h09
`define SRC_READY           5'h0A
`define SRC_LOW             5'h1E
`define SRC_NO_POLARITY     5'h1F

`endif

// ===== src/status_pin_pkg.sv
// Types shared by the status pin and startup gating logic
`include "status_pin_map.svh"
package status_pin_pkg;
    typedef enum logic [1:0] {
        GATE_APLL     = `GATE_ON_APLL,
        GATE_DPLL     = `GATE_ON_DPLL,
        GATE_OFF      = `GATE_NONE,
        GATE_RESVD    = `GATE_RESERVED
    } gate_mode_t;

    typedef enum logic [4:0] {
        S_APLL        = `SRC_APLL,
        S_DPLL        = `SRC_DPLL,
        S_REF0_LOSS   = `SRC_REF0_LOSS,
        S_REF1_LOSS   = `SRC_REF1_LOSS,
        S_XTAL_LOSS   = `SRC_XTAL_LOSS,
        S_REF0_ACT    = `SRC_REF0_ACT,
        S_REF1_ACT    = `SRC_REF1_ACT,
        S_REF0_INV    = `SRC_REF0_INVALID,
        S_REF1_INV    = `SRC_REF1_INVALID,
        S_INTERRUPT   = `SRC_INTERRUPT,
        S_READY       = `SRC_READY,
        S_LOW         = `SRC_LOW,
        S_NO_POL      = `SRC_NO_POLARITY
    } source_t;

    typedef logic [7:0]  reg_addr_t;
    typedef logic [15:0] reg_data_t;
endpackage
